// file: logic/hlc_counters.sv
// Lifetime health counters with a plain register port and power-up restore.
// Assumes event pulses and temperature come from logic on core_clk_in, and
// that a nonvolatile store restores the snapshot with one nv_load_in pulse.
//
// Functional notes
// - Written data units count; write-uncorrectable ignored.
// - Count completed Read and Compare commands.
// - Count completed Write commands.
// - Busy minutes while I/O commands outstanding.
// - Count power cycles.
// - Power-on hours, non-operational time excluded.
// - Unsafe shutdown when no notification before loss.
// - Count unrecovered data integrity errors.
// - Lifetime total of error log entries.
// - Minutes operational within warning temperature band.
// - Warning time zero when either threshold zero.
// - Data units in thousands of 512 bytes, rounded up.
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ns
module hlc_counters #(
  parameter logic [31:0] MINUTE_CYCLES = hlc_pkg::MINUTE_CYCLES,
  parameter int OUTST_W = 16
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire hlc_pkg::hlc_evt_type evt_in,
  input wire logic [15:0] temp_in,
  input wire logic operational_in,
  input wire logic nonop_state_in,
  input wire logic [1:0] shutdown_notify_field_in,
  input wire logic nv_load_in,
  input wire hlc_pkg::hlc_nv_type nv_restore_in,
  output hlc_pkg::hlc_nv_type nv_snapshot_out,
  input wire logic [8:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic irq_out
);
  localparam int NTMR = 3;
  localparam int TMR_BUSY = 0;
  localparam int TMR_WARN = 1;
  localparam int TMR_POH = 2;

  // Counters and the clean-shutdown flag are not reset: they survive resets
  logic [hlc_pkg::NCNT-1:0][127:0] cnt_r;
  logic [hlc_pkg::NCNT-1:0][1:0] inc;
  logic [31:0] warn_min_r, warn_min_nxt;
  logic clean_r, clean_nxt;
  logic [OUTST_W-1:0] outst_r, outst_nxt;
  logic [NTMR-1:0] tmr_cond, tick;
  logic [5:0] hour_min_r, hour_min_nxt;
  logic hour_tick;
  logic [31:0] du_pend_r, du_pend_nxt;
  logic [9:0] du_credit_r, du_credit_nxt;
  logic du_step;
  logic [15:0] warn_thr_r, warn_thr_nxt, crit_thr_r, crit_thr_nxt;
  logic [3:0] int_stat_r, int_stat_nxt, int_en_r, int_en_nxt, int_evt;
  logic [31:0] rdata_r, rdata_nxt;
  logic thr_zero, in_band;
  // Assertion helper: counters stay unknown until the first restore lands
  logic seen_load_r, seen_load_nxt;

  assign thr_zero = (warn_thr_r == 16'h0000) || (crit_thr_r == 16'h0000);
  assign in_band = (temp_in >= warn_thr_r) && (temp_in < crit_thr_r);

  // Outstanding I/O commands; doorbell accept and completion post may coincide
  always_comb begin
    seen_load_nxt = seen_load_r || nv_load_in;
    outst_nxt = outst_r;
    if (evt_in.sq_accept && !evt_in.cq_post) begin
      outst_nxt = outst_r + OUTST_W'(1);
    end else if (!evt_in.sq_accept && evt_in.cq_post && outst_r != '0) begin
      outst_nxt = outst_r - OUTST_W'(1);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      outst_r <= '0;
      seen_load_r <= 1'b0;
    end else begin
      outst_r <= outst_nxt;
      seen_load_r <= seen_load_nxt;
    end
  end

  assign tmr_cond[TMR_BUSY] = outst_r != '0;
  assign tmr_cond[TMR_WARN] = operational_in && in_band && !thr_zero;
  assign tmr_cond[TMR_POH] = !nonop_state_in;

  // Minute timers; a partial minute is lost on reset, a small undercount
  generate
    for (genvar t = 0; t < NTMR; t++) begin : g_tmr
      logic [31:0] tmr_r, tmr_nxt;
      always_comb begin
        tmr_nxt = tmr_r;
        tick[t] = 1'b0;
        if (tmr_cond[t]) begin
          if (tmr_r >= MINUTE_CYCLES - 32'h00000001) begin
            tmr_nxt = 32'h00000000;
            tick[t] = 1'b1;
          end else begin
            tmr_nxt = tmr_r + 32'h00000001;
          end
        end
      end
      always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
          tmr_r <= 32'h00000000;
        end else begin
          tmr_r <= tmr_nxt;
        end
      end
    end
  endgenerate

  // Minutes into the current power-on hour
  always_comb begin
    hour_min_nxt = hour_min_r;
    hour_tick = 1'b0;
    if (tick[TMR_POH]) begin
      if (hour_min_r == hlc_pkg::MIN_PER_HOUR - 6'h01) begin
        hour_min_nxt = 6'h00;
        hour_tick = 1'b1;
      end else begin
        hour_min_nxt = hour_min_r + 6'h01;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      hour_min_r <= 6'h00;
    end else begin
      hour_min_r <= hour_min_nxt;
    end
  end

  // Data units: one step buys 1000 units, so any started thousand counts
  always_comb begin
    logic [31:0] add;
    add = (evt_in.wr_done && !evt_in.wr_uncorr_done) ? evt_in.wr_units : 32'h00000000;
    du_pend_nxt = du_pend_r + add;
    du_credit_nxt = du_credit_r;
    du_step = 1'b0;
    if (du_pend_r != 32'h00000000) begin
      if (du_pend_r <= 32'(du_credit_r)) begin
        du_credit_nxt = du_credit_r - du_pend_r[9:0];
        du_pend_nxt = add;
      end else begin
        du_step = 1'b1;
        du_credit_nxt = hlc_pkg::DU_PER_STEP - 10'h001;
        du_pend_nxt = du_pend_r - 32'(du_credit_r) - 32'h00000001 + add;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      du_pend_r <= 32'h00000000;
      du_credit_r <= 10'h000;
    end else begin
      du_pend_r <= du_pend_nxt;
      du_credit_r <= du_credit_nxt;
    end
  end

  always_comb begin
    inc = '0;
    inc[hlc_pkg::CNT_DUW] = {1'b0, du_step};
    inc[hlc_pkg::CNT_RD] = 2'(evt_in.rd_done) + 2'(evt_in.cmp_done);
    inc[hlc_pkg::CNT_WR] = {1'b0, evt_in.wr_done};
    inc[hlc_pkg::CNT_BUSY] = {1'b0, tick[TMR_BUSY]};
    inc[hlc_pkg::CNT_POH] = {1'b0, hour_tick};
    inc[hlc_pkg::CNT_MEDIA] = 2'(evt_in.ecc_err) + 2'(evt_in.crc_err)
      + 2'(evt_in.tag_err);
    inc[hlc_pkg::CNT_ERRLOG] = {1'b0, evt_in.errlog_new};
  end

  // Restore marks a power-up: one more cycle, unsafe if no clean flag was saved
  generate
    for (genvar c = 0; c < hlc_pkg::NCNT; c++) begin : g_cnt
      logic [127:0] cnt_nxt;
      always_comb begin
        if (nv_load_in) begin
          cnt_nxt = nv_restore_in.cnt[c];
          if (c == hlc_pkg::CNT_PCYC) begin
            cnt_nxt = nv_restore_in.cnt[c] + 128'h1;
          end
          if (c == hlc_pkg::CNT_UNSAFE && !nv_restore_in.clean) begin
            cnt_nxt = nv_restore_in.cnt[c] + 128'h1;
          end
        end else begin
          cnt_nxt = cnt_r[c] + 128'(inc[c]);
        end
      end
      always_ff @(posedge core_clk_in) begin
        cnt_r[c] <= cnt_nxt;
      end
    end
  endgenerate

  always_comb begin
    clean_nxt = clean_r;
    if (nv_load_in) begin
      clean_nxt = 1'b0;
    end else if (shutdown_notify_field_in != 2'h0) begin
      clean_nxt = 1'b1;
    end
    warn_min_nxt = nv_load_in ? nv_restore_in.warn_min : warn_min_r + 32'(tick[TMR_WARN]);
    if (thr_zero) begin
      warn_min_nxt = 32'h00000000;
    end
  end

  always_ff @(posedge core_clk_in) begin
    clean_r <= clean_nxt;
    warn_min_r <= warn_min_nxt;
  end

  assign nv_snapshot_out.cnt = cnt_r;
  assign nv_snapshot_out.warn_min = warn_min_r;
  assign nv_snapshot_out.clean = clean_r;

  // Register port; reads answer the cycle after the strobe and only then
  always_comb begin
    logic [8:0] off;
    off = reg_addr_in - hlc_pkg::ADDR_CNT_BASE;
    int_evt = '0;
    int_evt[hlc_pkg::INT_UNSAFE] = nv_load_in && !nv_restore_in.clean;
    int_evt[hlc_pkg::INT_MEDIA] = inc[hlc_pkg::CNT_MEDIA] != 2'h0;
    int_evt[hlc_pkg::INT_ERRLOG] = evt_in.errlog_new;
    int_evt[hlc_pkg::INT_WARN] = tick[TMR_WARN];
    warn_thr_nxt = warn_thr_r;
    crit_thr_nxt = crit_thr_r;
    int_en_nxt = int_en_r;
    int_stat_nxt = int_stat_r;
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        hlc_pkg::ADDR_WARN_THR: warn_thr_nxt = reg_wdata_in[15:0];
        hlc_pkg::ADDR_CRIT_THR: crit_thr_nxt = reg_wdata_in[15:0];
        hlc_pkg::ADDR_INT_ENABLE: int_en_nxt = reg_wdata_in[3:0];
        hlc_pkg::ADDR_INT_CLEAR: int_stat_nxt = int_stat_r & ~reg_wdata_in[3:0];
        default: ;
      endcase
    end
    // A new event wins over a clear in the same cycle
    int_stat_nxt = int_stat_nxt | int_evt;
    rdata_nxt = 32'h00000000;
    if (reg_rd_in) begin
      if (reg_addr_in[1:0] == 2'h0 && reg_addr_in >= hlc_pkg::ADDR_CNT_BASE
          && reg_addr_in < hlc_pkg::ADDR_WARN_TIME) begin
        rdata_nxt = cnt_r[off[7:4]][32*off[3:2] +: 32];
      end else begin
        unique case (reg_addr_in)
          hlc_pkg::ADDR_WARN_TIME: rdata_nxt = warn_min_r;
          hlc_pkg::ADDR_WARN_THR: rdata_nxt = {16'h0000, warn_thr_r};
          hlc_pkg::ADDR_CRIT_THR: rdata_nxt = {16'h0000, crit_thr_r};
          hlc_pkg::ADDR_INT_STATUS: rdata_nxt = {28'h0000000, int_stat_r};
          hlc_pkg::ADDR_INT_ENABLE: rdata_nxt = {28'h0000000, int_en_r};
          default: rdata_nxt = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      warn_thr_r <= hlc_pkg::THR_RESET;
      crit_thr_r <= hlc_pkg::THR_RESET;
      int_en_r <= hlc_pkg::INT_RESET;
      int_stat_r <= hlc_pkg::INT_RESET;
      rdata_r <= 32'h00000000;
    end else begin
      warn_thr_r <= warn_thr_nxt;
      crit_thr_r <= crit_thr_nxt;
      int_en_r <= int_en_nxt;
      int_stat_r <= int_stat_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign irq_out = |(int_stat_r & int_en_r);

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_DU_UNCORR: assert property (
    (evt_in.wr_uncorr_done && !evt_in.wr_done && du_pend_r == 32'h00000000)
      |=> du_pend_r == 32'h00000000)
    else $error("write uncorrectable changed data units");
  AST_READS: assert property (
    (evt_in.rd_done && evt_in.cmp_done && !nv_load_in)
      |=> cnt_r[1] == $past(cnt_r[1]) + 128'h2)
    else $error("read count missed a command");
  AST_WRITES: assert property (
    (evt_in.wr_done && !nv_load_in) |=> cnt_r[2] == $past(cnt_r[2]) + 128'h1)
    else $error("write count missed a command");
  AST_BUSY_IDLE: assert property (
    (seen_load_r && outst_r == '0 && !nv_load_in)
      |=> cnt_r[3] == $past(cnt_r[3]))
    else $error("busy time grew while idle");
  AST_PCYC: assert property (
    nv_load_in |=> cnt_r[4] == $past(nv_restore_in.cnt[4]) + 128'h1)
    else $error("power cycle not counted");
  AST_POH_NONOP: assert property (
    nonop_state_in |=> $stable(g_tmr[2].tmr_r))
    else $error("hour timer ran in non-operational state");
  AST_UNSAFE: assert property (
    (nv_load_in && nv_restore_in.clean) |=> cnt_r[6] == $past(nv_restore_in.cnt[6]))
    else $error("clean shutdown counted as unsafe");
  AST_MEDIA: assert property (
    (evt_in.ecc_err && evt_in.crc_err && evt_in.tag_err && !nv_load_in)
      |=> cnt_r[7] == $past(cnt_r[7]) + 128'h3)
    else $error("integrity error not counted");
  AST_ERRLOG: assert property (
    (evt_in.errlog_new && !nv_load_in) |=> cnt_r[8] == $past(cnt_r[8]) + 128'h1)
    else $error("error log entry not counted");
  AST_WARN_OUT: assert property (
    (!(operational_in && in_band) && !thr_zero && !nv_load_in)
      |=> warn_min_r == $past(warn_min_r))
    else $error("warning time ran outside the band");
  AST_WARN_ZERO: assert property (
    thr_zero |=> warn_min_r == 32'h00000000)
    else $error("warning time not held at zero");
  AST_DU_STEP: assert property (
    (du_pend_r > 32'(du_credit_r) && !nv_load_in) |=> cnt_r[0] == $past(cnt_r[0]) + 128'h1)
    else $error("data unit step missed");
  AST_LE_READ: assert property (
    (reg_rd_in && reg_addr_in == 9'h040) |=> reg_rdata_out == $past(cnt_r[1][31:0]))
    else $error("read count low word misplaced");
  AST_UNSAFE_LOSS: assert property (
    (nv_load_in && !nv_restore_in.clean)
      |=> cnt_r[6] == $past(nv_restore_in.cnt[6]) + 128'h1)
    else $error("unsafe shutdown not counted");
  AST_MEDIA_FLAG: assert property (
    (inc[hlc_pkg::CNT_MEDIA] != 2'h0) |=> int_stat_r[hlc_pkg::INT_MEDIA])
    else $error("integrity error flag not raised");
  AST_RDATA_IDLE: assert property (
    !reg_rd_in |=> reg_rdata_out == 32'h00000000)
    else $error("read data stood without a read");
endmodule

// file: logic/hlc_pkg.sv
// Package for the lifetime health and usage counters.
// Assumes one 25 MHz core clock and a 9-bit word-aligned register port.
package hlc_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int MINUTE_S = 60;
  localparam logic [31:0] MINUTE_CYCLES = 32'(longint'(MINUTE_S) * longint'(CLK_HZ));
  localparam logic [5:0] MIN_PER_HOUR = 6'h3C;
  localparam logic [9:0] DU_PER_STEP = 10'h3E8;
  localparam int NCNT = 9;
  // Counter slots, in log order
  localparam int CNT_DUW = 0;
  localparam int CNT_RD = 1;
  localparam int CNT_WR = 2;
  localparam int CNT_BUSY = 3;
  localparam int CNT_PCYC = 4;
  localparam int CNT_POH = 5;
  localparam int CNT_UNSAFE = 6;
  localparam int CNT_MEDIA = 7;
  localparam int CNT_ERRLOG = 8;
  // Log byte offsets double as register byte addresses
  localparam logic [8:0] ADDR_CNT_BASE = 9'h030;
  localparam logic [8:0] ADDR_WARN_TIME = 9'h0C0;
  localparam logic [8:0] ADDR_WARN_THR = 9'h100;
  localparam logic [8:0] ADDR_CRIT_THR = 9'h104;
  localparam logic [8:0] ADDR_INT_STATUS = 9'h108;
  localparam logic [8:0] ADDR_INT_CLEAR = 9'h10C;
  localparam logic [8:0] ADDR_INT_ENABLE = 9'h110;
  localparam logic [15:0] THR_RESET = 16'h0000;
  localparam logic [3:0] INT_RESET = 4'h0;
  // Interrupt status bits
  localparam int INT_UNSAFE = 0;
  localparam int INT_MEDIA = 1;
  localparam int INT_ERRLOG = 2;
  localparam int INT_WARN = 3;

  typedef struct packed {
    logic wr_done;
    logic wr_uncorr_done;
    logic [31:0] wr_units;
    logic rd_done;
    logic cmp_done;
    logic sq_accept;
    logic cq_post;
    logic ecc_err;
    logic crc_err;
    logic tag_err;
    logic errlog_new;
  } hlc_evt_type;

  typedef struct packed {
    logic [NCNT-1:0][127:0] cnt;
    logic [31:0] warn_min;
    logic clean;
  } hlc_nv_type;
endpackage

// file: test/hlc_nv_store.sv
// Nonvolatile store model: hands the saved image back once after each reset.
// Assumes the counter block samples the image only with the load pulse.
`timescale 1ns/1ns
module hlc_nv_store #(
  parameter hlc_pkg::hlc_nv_type IMAGE = '0
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire hlc_pkg::hlc_nv_type nv_save_in,
  output logic nv_load_out,
  output hlc_pkg::hlc_nv_type nv_image_out
);
  logic loaded_r;
  // Two-state so the first power-up finds no saved copy and uses IMAGE
  bit have_save_r;
  hlc_pkg::hlc_nv_type saved_r;
  // Inverted outside the pulse so a stale sample shows up
  assign nv_image_out = nv_load_out ? (have_save_r ? saved_r : IMAGE) : ~IMAGE;
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      loaded_r <= 1'b0;
      nv_load_out <= 1'b0;
    end else begin
      nv_load_out <= !loaded_r;
      loaded_r <= 1'b1;
      // Saved every cycle once restored, as if flushed at power loss
      if (loaded_r && !nv_load_out) begin
        saved_r <= nv_save_in;
        have_save_r <= 1'b1;
      end
    end
  end
endmodule

// file: test/tb_health_log_counters.sv
// Self-checking bench for the health counters over the register port.
// Assumes the store model restores an image once, right after reset.
`timescale 1ns/1ns
module tb_health_log_counters;
  // Short minute keeps busy, warning and hour checks within a few thousand cycles
  localparam logic [31:0] MIN_CYC = 32'h14;
  localparam hlc_pkg::hlc_nv_type IMG = {896'h0, 128'h1_0000_0005, 128'h0, 33'h0};
  logic clk, rst_n, nv_load, wr, rd, irq, oper, nonop;
  logic [1:0] shn;
  logic [15:0] temp;
  logic [8:0] addr;
  logic [31:0] wdata, rdata;
  hlc_pkg::hlc_evt_type evt, e;
  hlc_pkg::hlc_nv_type img, snap;
  int fail_count, checks_done, cyc;

  hlc_nv_store #(.IMAGE(IMG)) NV (.core_clk_in(clk), .rst_n_in(rst_n),
    .nv_save_in(snap), .nv_load_out(nv_load), .nv_image_out(img));
  hlc_counters #(.MINUTE_CYCLES(MIN_CYC), .OUTST_W(16)) DUT (.core_clk_in(clk),
    .rst_n_in(rst_n), .evt_in(evt), .temp_in(temp), .operational_in(oper),
    .nonop_state_in(nonop), .shutdown_notify_field_in(shn), .nv_load_in(nv_load),
    .nv_restore_in(img), .nv_snapshot_out(snap), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .irq_out(irq));

  always #20 clk = ~clk;

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard: the tests need about 2700 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [8:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [8:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic rdchk(input logic [8:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd_reg(a, v);
    chk(v, exp);
  endtask

  // Growth of a counter across exactly k+2 cycles between the two reads
  task automatic delta(input logic [8:0] a, input int k, input logic [31:0] exp);
    logic [31:0] v0, v1;
    rd_reg(a, v0);
    repeat (k) @(posedge clk);
    rd_reg(a, v1);
    chk(v1 - v0, exp);
  endtask

  task automatic pulse(input hlc_pkg::hlc_evt_type p);
    @(posedge clk);
    evt <= p;
    @(posedge clk);
    evt <= '0;
  endtask

  task automatic irqchk(input logic exp);
    #1 chk({31'h0, irq}, {31'h0, exp});
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    evt = '0;
    temp = 16'h0000;
    oper = 1'b1;
    nonop = 1'b0;
    shn = 2'h0;
    addr = 9'h000;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk(9'h070, 32'h1);
    rdchk(9'h090, 32'h1);
    rdchk(9'h040, 32'h5);
    rdchk(9'h044, 32'h1);
    rdchk(hlc_pkg::ADDR_INT_STATUS, 32'h1);
    wr_reg(hlc_pkg::ADDR_INT_ENABLE, 32'hF);
    irqchk(1'b1);
    wr_reg(hlc_pkg::ADDR_INT_CLEAR, 32'h1);
    irqchk(1'b0);
    wr_reg(9'h040, 32'hFFFF_FFFF);
    rdchk(9'h040, 32'h5);
    rdchk(9'h1F0, 32'h0);
    @(posedge clk);
    shn <= 2'h1;
    @(posedge clk);
    #1 chk({31'h0, snap.clean}, 32'h1);
    $display("test restore done");
    e = '0;
    e.rd_done = 1'b1;
    pulse(e);
    e = '0;
    e.cmp_done = 1'b1;
    pulse(e);
    rdchk(9'h040, 32'h7);
    e = '0;
    e.rd_done = 1'b1;
    e.cmp_done = 1'b1;
    pulse(e);
    rdchk(9'h040, 32'h9);
    e = '0;
    e.wr_done = 1'b1;
    e.wr_units = 32'h1;
    pulse(e);
    e = '0;
    e.wr_uncorr_done = 1'b1;
    e.wr_units = 32'h10;
    pulse(e);
    repeat (3) @(posedge clk);
    rdchk(9'h050, 32'h1);
    rdchk(9'h030, 32'h1);
    e = '0;
    e.wr_done = 1'b1;
    e.wr_units = 32'h3E7;
    pulse(e);
    repeat (3) @(posedge clk);
    rdchk(9'h030, 32'h1);
    e.wr_units = 32'h1;
    pulse(e);
    repeat (3) @(posedge clk);
    rdchk(9'h030, 32'h2);
    rdchk(9'h050, 32'h3);
    $display("test commands done");
    e = '0;
    e.ecc_err = 1'b1;
    pulse(e);
    e = '0;
    e.crc_err = 1'b1;
    pulse(e);
    e = '0;
    e.tag_err = 1'b1;
    e.errlog_new = 1'b1;
    pulse(e);
    rdchk(9'h0A0, 32'h3);
    e = '0;
    e.ecc_err = 1'b1;
    e.crc_err = 1'b1;
    e.tag_err = 1'b1;
    pulse(e);
    rdchk(9'h0A0, 32'h6);
    rdchk(9'h0B0, 32'h1);
    rdchk(hlc_pkg::ADDR_INT_STATUS, 32'h6);
    irqchk(1'b1);
    wr_reg(hlc_pkg::ADDR_INT_CLEAR, 32'h6);
    irqchk(1'b0);
    $display("test errors done");
    e = '0;
    e.sq_accept = 1'b1;
    pulse(e);
    delta(9'h060, 18, 32'h1);
    e = '0;
    e.cq_post = 1'b1;
    pulse(e);
    delta(9'h060, 18, 32'h0);
    $display("test busy done");
    @(posedge clk);
    temp <= 16'h0040;
    delta(hlc_pkg::ADDR_WARN_TIME, 48, 32'h0);
    rdchk(hlc_pkg::ADDR_WARN_TIME, 32'h0);
    wr_reg(hlc_pkg::ADDR_WARN_THR, 32'h32);
    wr_reg(hlc_pkg::ADDR_CRIT_THR, 32'h64);
    delta(hlc_pkg::ADDR_WARN_TIME, 18, 32'h1);
    @(posedge clk);
    temp <= 16'h0064;
    delta(hlc_pkg::ADDR_WARN_TIME, 18, 32'h0);
    @(posedge clk);
    temp <= 16'h0032;
    oper <= 1'b0;
    delta(hlc_pkg::ADDR_WARN_TIME, 18, 32'h0);
    $display("test warning done");
    delta(9'h080, 1198, 32'h1);
    @(posedge clk);
    nonop <= 1'b1;
    delta(9'h080, 1198, 32'h0);
    $display("test hours done");
    // Power loss after a shutdown notice: values come back from the store
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk(9'h070, 32'h2);
    rdchk(9'h090, 32'h1);
    rdchk(9'h040, 32'h9);
    rdchk(hlc_pkg::ADDR_INT_STATUS, 32'h0);
    $display("test power loss done");
    test_done();
  end
endmodule
